// ===== src/cmdp_pkg.sv
// Shared constants, register map and types of the core memory data path
package cmdp_pkg;

    // Word layout
    localparam int DATA_W    = 16;
    localparam int WORD_W    = 17;
    localparam int PARITY_IX = 16;
    localparam int NUM_MOD   = 3;
    localparam int MOD_SEL_W = 2;

    // Timing: half-cycle lengths in ns and derived clock counts (least times round up)
    localparam int CLK_PERIOD_NS  = 20;
    localparam int READ_HALF_NS   = 400;
    localparam int WRITE_HALF_NS  = 400;
    localparam int READ_HALF_CYC  = (READ_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_HALF_CYC = (WRITE_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W          = 8;
    localparam logic [CNT_W-1:0] READ_LAST  = CNT_W'(READ_HALF_CYC - 1);
    localparam logic [CNT_W-1:0] WRITE_LAST = CNT_W'(WRITE_HALF_CYC - 1);

    // Register bus
    localparam int REG_ADDR_W = 4;
    localparam int REG_DATA_W = 32;
    localparam logic [REG_ADDR_W-1:0] REG_CTRL      = 4'h0;
    localparam logic [REG_ADDR_W-1:0] REG_LOADER    = 4'h4;
    localparam logic [REG_ADDR_W-1:0] REG_STATUS    = 4'h8;
    localparam logic [REG_ADDR_W-1:0] REG_LAST_READ = 4'hc;

    // Field positions and reset values
    localparam int CTRL_CHK_EN_BIT   = 0;
    localparam int STATUS_PERR_BIT   = 0;
    localparam int STATUS_BUSY_BIT   = 1;
    localparam int STATUS_LIVE_BIT   = 2;
    localparam int STATUS_STATE_LSB  = 4;
    localparam logic       CTRL_CHK_EN_RESET = 1'b1;
    localparam logic [15:0] WORD_RESET       = 16'h0000;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_READ  = 2'b01,
        ST_WRITE = 2'b10
    } cmdp_state_type;

    typedef enum logic [1:0] {
        OP_DATA_READ  = 2'b00,
        OP_DATA_WRITE = 2'b01,
        OP_INST_FETCH = 2'b10
    } cmdp_op_type;

endpackage

// ===== src/cmdp_par_if.sv
// Interface between the data path and its parity generator / checker
`timescale 1ns/1ps
interface cmdp_par_if;
    import cmdp_pkg::*;
    logic [DATA_W-1:0] gen_word;     // Word headed for the core modules
    logic              gen_odd_bit;  // Bit that makes the stored word odd
    logic [WORD_W-1:0] chk_word;     // Word returned from a module
    logic              chk_fail;     // Returned word has even weight

    modport parity (input gen_word, input chk_word, output gen_odd_bit, output chk_fail);
    modport user   (output gen_word, output chk_word, input gen_odd_bit, input chk_fail);
endinterface

// ===== src/cmdp_parity.sv
// Odd parity generator for writes and checker for reads
`timescale 1ns/1ps
module cmdp_parity (
    cmdp_par_if.parity par    // Parity words and results
);
    import cmdp_pkg::*;

    // Two XOR trees; an even data weight yields a one so the total stays odd
    assign par.gen_odd_bit = ~(^par.gen_word);
    // A correct word has odd weight over all seventeen lines
    assign par.chk_fail    = ~(^par.chk_word);
endmodule

// ===== src/cmdp_top.sv
// Processor side data path to the core memory modules
//
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module cmdp_top (
    input  wire logic                             clk_sys_i,              // 50 MHz clock
    input  wire logic                             srst_i,                 // Sync reset
    input  wire logic [cmdp_pkg::REG_ADDR_W-1:0]  reg_addr_i,             // Register byte address
    input  wire logic [cmdp_pkg::REG_DATA_W-1:0]  reg_wdata_i,            // Write data
    input  wire logic                             reg_wr_i,               // Write strobe
    input  wire logic                             reg_rd_i,               // Read strobe
    output logic      [cmdp_pkg::REG_DATA_W-1:0]  reg_rdata_o,            // Read data, next cycle
    input  wire logic                             cycle_start_i,          // Start memory cycle
    input  wire logic                             data_read_op_i,         // Data read
    input  wire logic                             data_write_op_i,        // Data write
    input  wire logic                             instruction_fetch_op_i, // Microinstruction read
    input  wire logic [cmdp_pkg::MOD_SEL_W-1:0]   module_sel_i,           // Decoded module index
    output logic                                  busy_o,                 // Cycle in progress
    input  wire logic [cmdp_pkg::DATA_W-1:0]      memory_info_reg_i,      // Processor write word
    input  wire logic                             loader_write_select_i,  // Loader owns writes
    input  wire logic                             loader_shift_en_i,      // Shift one loader bit
    input  wire logic                             loader_shift_bit_i,     // Serial loader bit
    input  wire logic                             bus_exchange_instr_i,   // Bus exchange active
    input  wire logic [cmdp_pkg::DATA_W-1:0]      external_bus_n_i,       // Bus level, active low
    output logic      [cmdp_pkg::DATA_W-1:0]      external_bus_n_o,       // Bus drive, active low
    output logic                                  external_bus_oe_o,      // Bus drive enable
    output logic                                  read_data_bus_gate_o,   // Read data on bus
    output logic      [cmdp_pkg::DATA_W-1:0]      shared_write_data_o,    // Shared data lines
    output logic                                  write_parity_bit_o,     // Bit seventeen
    output logic      [cmdp_pkg::NUM_MOD-1:0]     module_write_strobe_o,  // Per module, high
    output logic      [cmdp_pkg::NUM_MOD-1:0]     data_out_strobe_n_o,    // Per module, low
    input  wire logic [cmdp_pkg::WORD_W-1:0]      return_data_line_i,     // From modules
    output logic                                  read_latch_clock_n_o,   // Latch pulse, low
    output logic                                  read_parity_error_o,    // Last check failed
    output logic      [cmdp_pkg::DATA_W-1:0]      mpm_data_o,             // Microprogram lines
    output logic                                  mpm_valid_o             // Fetch word pulse
);
    import cmdp_pkg::*;

    cmdp_par_if par ();

    cmdp_parity u_parity (
        .par (par.parity)
    );

    cmdp_state_type          state_q, state_d;
    cmdp_op_type             op_q, op_d;
    logic [NUM_MOD-1:0]      mod_q, mod_d;
    logic [CNT_W-1:0]        cnt_q, cnt_d;
    logic [NUM_MOD-1:0]      dos_n_q, dos_n_d;
    logic [NUM_MOD-1:0]      wstb_q, wstb_d;
    logic [DATA_W-1:0]       wdata_q, wdata_d;
    logic                    wpar_q, wpar_d;
    logic                    latch_clk_n_q, latch_clk_n_d;
    logic [DATA_W-1:0]       latch_q, latch_d;
    logic [DATA_W-1:0]       mpm_q, mpm_d;
    logic                    mpm_vld_q, mpm_vld_d;
    logic                    perr_q, perr_d;
    logic                    check_now;
    logic [DATA_W-1:0]       write_src;

    logic [WORD_W-1:0]       ret_meta_q, ret_sync_q;
    logic [DATA_W-1:0]       ext_meta_q, ext_sync_q;

    logic                    chk_en_q, chk_en_d;
    logic                    sticky_q, sticky_d;
    logic [DATA_W-1:0]       shift_q, shift_d;
    logic [REG_DATA_W-1:0]   rdata_q, rdata_d;

    // Pins from the modules and the bus cross two flops before any logic looks at them
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            ret_meta_q <= '0;
            ret_sync_q <= '0;
            ext_meta_q <= '1;
            ext_sync_q <= '1;
        end else begin
            ret_meta_q <= return_data_line_i;
            ret_sync_q <= ret_meta_q;
            ext_meta_q <= external_bus_n_i;
            ext_sync_q <= ext_meta_q;
        end
    end

    // Write source: loader bus word or processor information register word
    always_comb begin
        if (loader_write_select_i) begin
            write_src = ~ext_sync_q;
        end else begin
            write_src = ~(~memory_info_reg_i);
        end
    end

    assign par.gen_word = write_src;
    assign par.chk_word = ret_sync_q;
    // Check on the last read-half cycle, while the strobe still holds the lines
    assign check_now    = (state_q == ST_READ) && (cnt_q == '0) && (op_q != OP_DATA_WRITE);

    // Memory cycle sequencer: read half, then write half
    always_comb begin
        state_d       = state_q;
        op_d          = op_q;
        mod_d         = mod_q;
        cnt_d         = cnt_q;
        dos_n_d       = dos_n_q;
        wstb_d        = wstb_q;
        wdata_d       = wdata_q;
        wpar_d        = wpar_q;
        latch_clk_n_d = 1'b1;
        latch_d       = latch_q;
        mpm_d         = mpm_q;
        mpm_vld_d     = 1'b0;
        perr_d        = perr_q;
        case (state_q)
            ST_IDLE: begin
                if (cycle_start_i) begin
                    if (data_write_op_i || loader_write_select_i) begin
                        op_d = OP_DATA_WRITE;
                    end else if (instruction_fetch_op_i) begin
                        op_d = OP_INST_FETCH;
                    end else begin
                        op_d = OP_DATA_READ;
                    end
                    mod_d   = '0;
                    mod_d[module_sel_i] = 1'b1;
                    cnt_d   = READ_LAST;
                    state_d = ST_READ;
                    // A write discards the old word, so no module is asked to drive it
                    if (!(data_write_op_i || loader_write_select_i)) begin
                        dos_n_d = '1;
                        dos_n_d[module_sel_i] = 1'b0;
                    end
                end
            end
            ST_READ: begin
                if (cnt_q == '0) begin
                    dos_n_d = '1;
                    cnt_d   = WRITE_LAST;
                    state_d = ST_WRITE;
                    if (op_q == OP_DATA_WRITE) begin
                        // Word and parity frozen here so they stay put under the strobe
                        wdata_d = write_src;
                        wpar_d  = par.gen_odd_bit;
                        wstb_d  = mod_q;
                    end
                    if (op_q == OP_DATA_READ) begin
                        latch_clk_n_d = 1'b0;
                        latch_d       = ret_sync_q[DATA_W-1:0];
                    end
                    if (op_q == OP_INST_FETCH) begin
                        mpm_d     = ret_sync_q[DATA_W-1:0];
                        mpm_vld_d = 1'b1;
                    end
                    if (check_now) begin
                        perr_d = par.chk_fail && chk_en_q;
                    end
                end else begin
                    cnt_d = cnt_q - CNT_W'(1);
                end
            end
            ST_WRITE: begin
                // Reads need no strobe here: the module restores from its own buffer
                if (cnt_q == '0) begin
                    wstb_d  = '0;
                    state_d = ST_IDLE;
                end else begin
                    cnt_d = cnt_q - CNT_W'(1);
                end
            end
            default: begin
                state_d = ST_IDLE;
                dos_n_d = '1;
                wstb_d  = '0;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            state_q       <= ST_IDLE;
            op_q          <= OP_DATA_READ;
            mod_q         <= '0;
            cnt_q         <= '0;
            dos_n_q       <= '1;
            wstb_q        <= '0;
            wdata_q       <= WORD_RESET;
            wpar_q        <= 1'b1;
            latch_clk_n_q <= 1'b1;
            latch_q       <= WORD_RESET;
            mpm_q         <= WORD_RESET;
            mpm_vld_q     <= 1'b0;
            perr_q        <= 1'b0;
        end else begin
            state_q       <= state_d;
            op_q          <= op_d;
            mod_q         <= mod_d;
            cnt_q         <= cnt_d;
            dos_n_q       <= dos_n_d;
            wstb_q        <= wstb_d;
            wdata_q       <= wdata_d;
            wpar_q        <= wpar_d;
            latch_clk_n_q <= latch_clk_n_d;
            latch_q       <= latch_d;
            mpm_q         <= mpm_d;
            mpm_vld_q     <= mpm_vld_d;
            perr_q        <= perr_d;
        end
    end

    // Register file, loader shift register and sticky parity flag
    always_comb begin
        chk_en_d = chk_en_q;
        sticky_d = sticky_q;
        shift_d  = shift_q;
        rdata_d  = '0;
        if (reg_wr_i && reg_addr_i == REG_CTRL) begin
            chk_en_d = reg_wdata_i[CTRL_CHK_EN_BIT];
        end
        if (reg_wr_i && reg_addr_i == REG_LOADER) begin
            shift_d = reg_wdata_i[DATA_W-1:0];
        end else if (loader_shift_en_i) begin
            shift_d = {shift_q[DATA_W-2:0], loader_shift_bit_i};
        end
        if (reg_wr_i && reg_addr_i == REG_STATUS && reg_wdata_i[STATUS_PERR_BIT]) begin
            sticky_d = 1'b0;
        end
        // A failing check in the clearing cycle still leaves the flag set
        if (check_now && par.chk_fail && chk_en_q) begin
            sticky_d = 1'b1;
        end
        if (reg_rd_i) begin
            case (reg_addr_i)
                REG_CTRL: begin
                    rdata_d[CTRL_CHK_EN_BIT] = chk_en_q;
                end
                REG_LOADER: begin
                    rdata_d[DATA_W-1:0] = shift_q;
                end
                REG_STATUS: begin
                    rdata_d[STATUS_PERR_BIT] = sticky_q;
                    rdata_d[STATUS_BUSY_BIT] = (state_q != ST_IDLE);
                    rdata_d[STATUS_LIVE_BIT] = perr_q;
                    rdata_d[STATUS_STATE_LSB +: 2] = state_q;
                end
                REG_LAST_READ: begin
                    rdata_d[DATA_W-1:0] = latch_q;
                end
                default: begin
                    rdata_d = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            chk_en_q <= CTRL_CHK_EN_RESET;
            sticky_q <= 1'b0;
            shift_q  <= WORD_RESET;
            rdata_q  <= '0;
        end else begin
            chk_en_q <= chk_en_d;
            sticky_q <= sticky_d;
            shift_q  <= shift_d;
            rdata_q  <= rdata_d;
        end
    end

    // Bus drive: the loader has priority, so a bus exchange cannot fight it
    assign read_data_bus_gate_o  = bus_exchange_instr_i && !loader_write_select_i;
    assign external_bus_oe_o     = loader_write_select_i || read_data_bus_gate_o;
    assign external_bus_n_o      = loader_write_select_i ? ~shift_q : ~latch_q;

    // Module facing and processor facing outputs
    assign shared_write_data_o   = wdata_q;
    assign write_parity_bit_o    = wpar_q;
    assign module_write_strobe_o = wstb_q;
    assign data_out_strobe_n_o   = dos_n_q;
    assign read_latch_clock_n_o  = latch_clk_n_q;
    assign read_parity_error_o   = perr_q;
    assign mpm_data_o            = mpm_q;
    assign mpm_valid_o           = mpm_vld_q;
    assign busy_o                = (state_q != ST_IDLE);
    assign reg_rdata_o           = rdata_q;

endmodule

// ===== test/cmdp_monitor.sv
// Concurrent checks on the core memory data path top ports
`timescale 1ns/1ps
module cmdp_monitor (
    input wire logic        clk_sys_i,             // System clock
    input wire logic        srst_i,                // Sync reset
    input wire logic        cycle_start_i,         // Start memory cycle
    input wire logic        data_write_op_i,       // Data write
    input wire logic [1:0]  module_sel_i,          // Module index
    input wire logic        busy_o,                // Cycle in progress
    input wire logic        loader_write_select_i, // Loader owns writes
    input wire logic        bus_exchange_instr_i,  // Bus exchange
    input wire logic        external_bus_oe_o,     // Bus drive enable
    input wire logic        read_data_bus_gate_o,  // Read data on bus
    input wire logic [15:0] shared_write_data_o,   // Shared data lines
    input wire logic        write_parity_bit_o,    // Bit seventeen
    input wire logic [2:0]  module_write_strobe_o, // Write strobes
    input wire logic [2:0]  data_out_strobe_n_o,   // Data out strobes, low
    input wire logic        read_latch_clock_n_o,  // Latch pulse, low
    input wire logic        read_parity_error_o,   // Parity error
    input wire logic        mpm_valid_o            // Fetch word pulse
);
    logic [7:0] busy_cnt_q, busy_cnt_d, dos_cnt_q, dos_cnt_d;
    // Cycle counters, since the half lengths exceed any repetition count
    always_comb begin
        busy_cnt_d = (srst_i || !busy_o) ? 8'h00 : busy_cnt_q + 8'h01;
        dos_cnt_d  = (srst_i || &data_out_strobe_n_o) ? 8'h00 : dos_cnt_q + 8'h01;
    end
    always_ff @(posedge clk_sys_i) begin
        busy_cnt_q <= busy_cnt_d;
        dos_cnt_q  <= dos_cnt_d;
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);
    chk_cycle_len: assert property ($fell(busy_o) |-> busy_cnt_q == 8'd40)
        else $error("Memory cycle length wrong");
    chk_read_half: assert property ($rose(&data_out_strobe_n_o) |-> dos_cnt_q == 8'd20)
        else $error("Data out strobe length wrong");
    chk_start_taken: assert property (cycle_start_i && !busy_o |=> busy_o)
        else $error("Start not taken");
    chk_dos_select: assert property (cycle_start_i && !busy_o && !data_write_op_i
        && !loader_write_select_i |=> $countones(~data_out_strobe_n_o) == 1
        && !data_out_strobe_n_o[$past(module_sel_i)]) else $error("Wrong module strobed");
    chk_wstb_alone: assert property (module_write_strobe_o != 3'b000
        |-> $onehot(module_write_strobe_o) && &data_out_strobe_n_o) else $error("Write strobe bad");
    chk_src_stable: assert property ($past(module_write_strobe_o) != 3'b000
        && module_write_strobe_o != 3'b000 |-> $stable(shared_write_data_o)
        && $stable(write_parity_bit_o)) else $error("Write source moved under strobe");
    chk_parity_odd: assert property (write_parity_bit_o == ~(^shared_write_data_o))
        else $error("Write parity not odd");
    chk_latch_pulse: assert property (!read_latch_clock_n_o |-> &data_out_strobe_n_o
        && $past(data_out_strobe_n_o) != 3'b111 && !mpm_valid_o ##1 read_latch_clock_n_o)
        else $error("Latch clock pulse misplaced");
    chk_mpm_pulse: assert property (mpm_valid_o |-> $past(data_out_strobe_n_o) != 3'b111
        ##1 !mpm_valid_o) else $error("Microprogram pulse misplaced");
    chk_bus_gate: assert property (read_data_bus_gate_o == (bus_exchange_instr_i
        && !loader_write_select_i) && external_bus_oe_o == (loader_write_select_i
        || read_data_bus_gate_o)) else $error("Bus gate wrong");
    chk_perr_moment: assert property (!$stable(read_parity_error_o)
        |-> $past(data_out_strobe_n_o) != 3'b111) else $error("Parity error moved off check");
endmodule
bind cmdp_top cmdp_monitor i_cmdp_monitor (.clk_sys_i, .srst_i, .cycle_start_i, .data_write_op_i,
    .module_sel_i, .busy_o, .loader_write_select_i, .bus_exchange_instr_i, .external_bus_oe_o,
    .read_data_bus_gate_o, .shared_write_data_o, .write_parity_bit_o, .module_write_strobe_o,
    .data_out_strobe_n_o, .read_latch_clock_n_o, .read_parity_error_o, .mpm_valid_o);

// ===== test/cmdp_core_model.sv
// Behavioural model of the three core memory modules
`timescale 1ns/1ps
module cmdp_core_model (
    input  wire logic        clk_sys_i, // System clock
    input  wire logic [2:0]  wstb_i,    // Write strobe per module
    input  wire logic [2:0]  dos_n_i,   // Data out strobe per module, low
    input  wire logic [15:0] wdata_i,   // Shared write data
    input  wire logic        wpar_i,    // Write parity bit
    input  wire logic        bad_i,     // Flip line one on the cable
    output logic      [16:0] ret_o      // Return data lines
);
    logic [8:0]  board_lo [3]; // Bits 1 to 9
    logic [8:0]  board_hi [3]; // Bits 10 to 16, parity, spare latch
    logic [16:0] last_q = '0;
    // Latch on the strobe; inhibit drivers follow the latches plane for plane
    // Strobe marks the write half, with drive current opposite to the read half, so a module
    // still driving its lines (read half) never latches; one stack area per module, since
    // the stack-size address bit does not pass through this block
    always @(posedge clk_sys_i)
        for (int m = 0; m < 3; m++)
            if (wstb_i[m] && dos_n_i[m]) begin
                board_lo[m] <= wdata_i[8:0];
                board_hi[m] <= {1'b0, wpar_i, wdata_i[15:9]};
            end
    // Sensed word goes back; it is restored in the write half, so a read never alters it
    always_comb begin
        ret_o = ~last_q; // Released lines show no stale word
        for (int m = 0; m < 3; m++)
            if (!dos_n_i[m]) ret_o = {board_hi[m][7:0], board_lo[m]} ^ 17'(bad_i);
    end
    always @(posedge clk_sys_i)
        if (dos_n_i != 3'b111) last_q <= ret_o;
endmodule

// ===== test/test_core_memory_data_path.sv
// Self-checking bench of the core memory data path
`timescale 1ns/1ps
module test_core_memory_data_path;
    import cmdp_pkg::*;
`define CMP(nm, e, s) begin n_tests++; if ((e) !== (s)) begin bad_count++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, s); end end
    logic        clk_sys_i, srst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, cycle_start_i = 1'b0;
    logic [3:0]  reg_addr_i = 4'h0;
    logic [31:0] reg_wdata_i = '0, reg_rdata_o, seed = 32'h25c3265e;
    logic        data_read_op_i = 1'b0, data_write_op_i = 1'b0, instruction_fetch_op_i = 1'b0;
    logic [1:0]  module_sel_i = 2'h0;
    logic [15:0] memory_info_reg_i = '0, drv_bus_n = '0, ext_o, sdata, mpm_data_o, ldv;
    logic        loader_write_select_i = 1'b0, loader_shift_en_i = 1'b0, loader_shift_bit_i = 1'b0;
    logic        bus_exchange_instr_i = 1'b0, bad = 1'b0, busy_o, ext_oe, wpar, lclk_n, perr;
    logic        mpm_valid_o, rd_d = 1'b0, w_d = 1'b0, r_d = 1'b0, r_m = 1'b0;
    logic [2:0]  wstb, dos_n;
    logic [16:0] ret;
    logic [15:0] exp_mem [3], r_w;
    logic [31:0] rq[$], exp_rd;
    logic [19:0] exp_mw;
    logic [19:0] q[$];
    int          bad_count = 0, n_tests = 0, i, k;
    wire  [15:0] ext_wire = ext_oe ? ext_o : drv_bus_n; // Bench drives when design is off

    cmdp_top i_cmdp_top (.clk_sys_i, .srst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
        .reg_rdata_o, .cycle_start_i, .data_read_op_i, .data_write_op_i, .instruction_fetch_op_i,
        .module_sel_i, .busy_o, .memory_info_reg_i, .loader_write_select_i, .loader_shift_en_i,
        .loader_shift_bit_i, .bus_exchange_instr_i, .external_bus_n_i(ext_wire),
        .external_bus_n_o(ext_o), .external_bus_oe_o(ext_oe), .read_data_bus_gate_o(),
        .shared_write_data_o(sdata), .write_parity_bit_o(wpar), .module_write_strobe_o(wstb),
        .data_out_strobe_n_o(dos_n), .return_data_line_i(ret), .read_latch_clock_n_o(lclk_n),
        .read_parity_error_o(perr), .mpm_data_o, .mpm_valid_o);
    cmdp_core_model i_cmdp_core_model (.clk_sys_i, .wstb_i(wstb), .dos_n_i(dos_n),
        .wdata_i(sdata), .wpar_i(wpar), .bad_i(bad), .ret_o(ret));

    // Clock, 20 ns period
    initial begin
        clk_sys_i = 1'b0;
        forever #10 clk_sys_i = ~clk_sys_i;
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic tick(int n = 1);
        repeat (n) @(posedge clk_sys_i);
    endtask
    // One register cycle; strobes are not lowered here, so calls can follow back to back
    task automatic bus(logic w, logic [3:0] a, logic [31:0] d);
        reg_wr_i <= w;
        reg_rd_i <= !w;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        if (!w) rq.push_back(d);
        tick();
    endtask
    // One memory cycle, with a second start inside it that must be ignored
    task automatic mem(cmdp_op_type op, int m, logic ldr, logic b);
        logic [31:0] r;
        r = xs();
        if (op == OP_DATA_WRITE) begin
            exp_mem[m] = ldr ? ldv : r[15:0];
            q.push_back({3'b001 << m, ~^exp_mem[m], exp_mem[m]});
        end else
            q.push_back({3'b000, b, exp_mem[m] ^ 16'(b)});
        data_read_op_i <= op == OP_DATA_READ;
        data_write_op_i <= op == OP_DATA_WRITE;
        instruction_fetch_op_i <= op == OP_INST_FETCH;
        module_sel_i <= 2'(m);
        loader_write_select_i <= ldr;
        memory_info_reg_i <= (op == OP_DATA_WRITE && !ldr) ? exp_mem[m] : r[15:0];
        bus_exchange_instr_i <= r[16];
        drv_bus_n <= r[31:16];
        bad <= b;
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b0;
        cycle_start_i <= 1'b1;
        tick();
        cycle_start_i <= 1'b0;
        tick(4);
        cycle_start_i <= 1'b1;
        tick();
        cycle_start_i <= 1'b0;
        for (k = 0; k < 100; k++) begin
            @(negedge clk_sys_i);
            if (busy_o === 1'b0) break;
        end
        if (k == 100) begin
            bad_count++;
            close_out();
        end
        tick(2);
        $display("Done: %s on module %0d", op.name(), m);
    endtask
    task automatic close_out();
        // A result that never showed up leaves its note behind and counts as a mismatch
        if (q.size() != 0 || rq.size() != 0) bad_count++;
        $display("Compared %0d, mismatched %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // Result watcher: old output values are seen at each rising edge
    // Notes are taken off once, so a mismatch report cannot eat the next note
    always @(posedge clk_sys_i) begin
        if (rd_d) begin
            exp_rd = rq.pop_front();
            `CMP("register read", exp_rd, reg_rdata_o)
        end
        rd_d <= reg_rd_i;
        if (wstb != 3'b000 && !w_d) begin
            exp_mw = q.pop_front();
            `CMP("write word", exp_mw, {wstb, wpar, sdata})
        end
        w_d <= wstb != 3'b000;
        if (r_d) begin
            exp_mw = q.pop_front();
            `CMP("read word", exp_mw, {3'b000, perr, r_m ? r_w : ~ext_o})
        end
        r_d <= mpm_valid_o | !lclk_n;
        r_m <= mpm_valid_o;
        r_w <= mpm_data_o;
    end

    // Main sequence
    initial begin
        tick(10);
        srst_i <= 1'b0;
        tick();
        bus(0, REG_CTRL, 32'h1);
        bus(0, REG_STATUS, 32'h0);
        bus(0, REG_LAST_READ, 32'h0);
        bus(1, 4'h1, 32'hffffffff);
        bus(0, 4'h1, 32'h0); // Unmapped address
        $display("Done: register reset values");
        for (i = 0; i < 3; i++) mem(OP_DATA_WRITE, i, 1'b0, 1'b0);
        for (i = 0; i < 3; i++) mem(OP_DATA_READ, i, 1'b0, 1'b0);
        mem(OP_INST_FETCH, 2, 1'b0, 1'b0);
        ldv = 16'(xs());
        bus(1, REG_LOADER, {16'h0, ldv});
        reg_wr_i <= 1'b0;
        for (i = 0; i < 3; i++) begin
            loader_shift_en_i <= 1'b1;
            loader_shift_bit_i <= seed[i];
            ldv = {ldv[14:0], seed[i]};
            tick();
        end
        loader_shift_en_i <= 1'b0;
        bus(0, REG_LOADER, {16'h0, ldv});
        mem(OP_DATA_WRITE, 1, 1'b1, 1'b0);
        mem(OP_INST_FETCH, 1, 1'b0, 1'b0);
        mem(OP_DATA_READ, 0, 1'b0, 1'b1);
        bus(0, REG_STATUS, 32'h5);
        bus(1, REG_STATUS, 32'h1);
        bus(0, REG_STATUS, 32'h4);
        bus(0, REG_LAST_READ, {16'h0, exp_mem[0] ^ 16'h0001});
        bus(1, REG_CTRL, 32'h0);
        bus(0, REG_CTRL, 32'h0);
        bus(1, REG_CTRL, 32'h1);
        mem(OP_DATA_READ, 2, 1'b0, 1'b0);
        $display("Done: status and control registers");
        tick(3);
        close_out();
    end
endmodule
